// File: rtl/srmc_regs.vh
// register map and timing constants for the small ram controller
// assumes a 25 MHz aclk and one attached 32x2 latch ram
`ifndef SRMC_REGS_VH
`define SRMC_REGS_VH
// axi4-lite byte offsets
`define SRMC_CTRL_OFF 4'h0
`define SRMC_ADDR_OFF 4'h4
`define SRMC_DATA_OFF 4'h8
`define SRMC_STAT_OFF 4'hc
// ctrl fields
`define SRMC_CTRL_GO 0
`define SRMC_CTRL_WR 1
`define SRMC_CTRL_HOLD 2
`define SRMC_CTRL_BYP 3
// data fields: data [1:0], mask [5:4]
`define SRMC_DATA_LO 0
`define SRMC_MASK_LO 4
// status fields
`define SRMC_STAT_BUSY 0
`define SRMC_STAT_RD_LO 4
// least setup time before the strobe, in ns, and its cycle count
`define SRMC_SETUP_NS 40
`define SRMC_CLK_NS 40
`define SRMC_SETUP_CYC ((`SRMC_SETUP_NS + `SRMC_CLK_NS - 1) / `SRMC_CLK_NS)
`define SRMC_RESP_OKAY 2'b00
`define SRMC_RESP_SLVERR 2'b10
`endif

// File: rtl/srmc_ctrl.v
// controller driving a 32x2 ram with write strobe and output latch
// assumes ram pins sampled synchronously to aclk; software via axi4-lite
`timescale 1ns/1ps
`include "srmc_regs.vh"

// Function
// RULE_01: ram holds 32 words of 2 bits, usable as one or two stores.
// RULE_02: upper address bit selects the array half for read and write.
// RULE_03: address changes never disturb unselected cells.
// RULE_04: latch keeps data while chip is disabled; latch independent of enable.
// RULE_05: separate latch and enable let shared-bus parts read while others addressed.
// RULE_06: held write: disable chip, assert hold, re-enable, then write.
// RULE_07: per-bit enables with common strobe write either bit or both.
// RULE_08: bit written only while strobe and its enable are both low.
// RULE_09: enables come from a clocked register; strobe is clock-timed.
// RULE_10: write happens on the strobe edge, not other input settling.
// RULE_11: mask is inverted onto the active-low per-bit enables.
// RULE_12: latch bypass gives plain ram; otherwise holds data during writes.
// RULE_13: hold inactive passes data through; active freezes last value.
module srmc_ctrl #(
  parameter ADDR_W = 5,
  parameter DATA_W = 2
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // ram pins
  output reg [ADDR_W-1:0] ram_addr,
  output reg [DATA_W-1:0] ram_wdata,
  output reg [DATA_W-1:0] per_bit_write_enable_n,
  output reg write_strobe_n,
  output reg chip_enable_n,
  output reg latch_hold,
  input wire [DATA_W-1:0] ram_rdata
);

  localparam ST_IDLE = 3'h0;
  localparam ST_DIS = 3'h1;
  localparam ST_HOLD = 3'h2;
  localparam ST_EN = 3'h3;
  localparam ST_STB = 3'h4;
  localparam ST_END = 3'h5;
  localparam ST_READ = 3'h6;

  // register decode codes
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_CTRL = 3'h1;
  localparam [2:0] SEL_ADDR = 3'h2;
  localparam [2:0] SEL_DATA = 3'h3;
  localparam [2:0] SEL_STAT = 3'h4;

  // all bit writes blocked
  localparam [DATA_W-1:0] WEN_IDLE = {DATA_W{1'b1}};
  localparam [7:0] SETUP_CYC = `SRMC_SETUP_CYC;
  localparam [7:0] WAIT_STEP = 8'h01;

  // register decode shared by write and read paths
  function [2:0] reg_sel;
    input [3:0] off;
    begin
      case (off)
        `SRMC_CTRL_OFF: reg_sel = SEL_CTRL;
        `SRMC_ADDR_OFF: reg_sel = SEL_ADDR;
        `SRMC_DATA_OFF: reg_sel = SEL_DATA;
        `SRMC_STAT_OFF: reg_sel = SEL_STAT;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // positive mask onto active-low enables
  function [DATA_W-1:0] mask_to_wen;
    input [DATA_W-1:0] mask;
    begin
      mask_to_wen = ~mask;
    end
  endfunction

  // data register readback: data and mask
  function [31:0] data_word;
    input [DATA_W-1:0] data;
    input [DATA_W-1:0] mask;
    begin
      data_word = 32'h0000_0000;
      data_word[`SRMC_DATA_LO +: DATA_W] = data;
      data_word[`SRMC_MASK_LO +: DATA_W] = mask;
    end
  endfunction

  // status readback: busy and last read data
  function [31:0] stat_word;
    input busy_bit;
    input [DATA_W-1:0] rd;
    begin
      stat_word = 32'h0000_0000;
      stat_word[`SRMC_STAT_BUSY] = busy_bit;
      stat_word[`SRMC_STAT_RD_LO +: DATA_W] = rd;
    end
  endfunction

  // sequencer and software registers
  reg [2:0] state_reg;
  reg [3:0] ctrl_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [DATA_W-1:0] data_reg;
  reg [DATA_W-1:0] mask_reg;
  reg [DATA_W-1:0] rd_reg;
  // axi capture
  reg [3:0] awaddr_reg;
  reg aw_have_reg;
  reg w_have_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [7:0] wait_reg;
  // start request
  reg go_reg;

  wire busy = (state_reg != ST_IDLE);
  wire hold_req = ctrl_reg[`SRMC_CTRL_HOLD] & ~ctrl_reg[`SRMC_CTRL_BYP];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SRMC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SRMC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      ctrl_reg <= 4'h0;
      addr_reg <= {ADDR_W{1'b0}};
      data_reg <= {DATA_W{1'b0}};
      mask_reg <= {DATA_W{1'b0}};
      go_reg <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      // write commit once both halves held
      if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SRMC_RESP_OKAY;
        case (reg_sel(awaddr_reg))
          SEL_CTRL: begin
            if (wstrb_reg[0]) begin
              ctrl_reg[`SRMC_CTRL_GO] <= 1'b0;
              ctrl_reg[`SRMC_CTRL_WR] <= wdata_reg[`SRMC_CTRL_WR];
              ctrl_reg[`SRMC_CTRL_HOLD] <= wdata_reg[`SRMC_CTRL_HOLD];
              ctrl_reg[`SRMC_CTRL_BYP] <= wdata_reg[`SRMC_CTRL_BYP];
              // go only starts an idle sequencer
              go_reg <= wdata_reg[`SRMC_CTRL_GO] & ~busy;
            end
          end
          SEL_ADDR: begin
            if (wstrb_reg[0] && !busy)
              addr_reg <= wdata_reg[ADDR_W-1:0];
          end
          SEL_DATA: begin
            if (wstrb_reg[0] && !busy) begin
              data_reg <= wdata_reg[`SRMC_DATA_LO +: DATA_W];
              mask_reg <= wdata_reg[`SRMC_MASK_LO +: DATA_W];
            end
          end
          SEL_STAT: ;
          default: s_axi_bresp <= `SRMC_RESP_SLVERR;
        endcase
      end
      // write response handshake
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // read channel
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SRMC_RESP_OKAY;
        case (reg_sel(s_axi_araddr))
          SEL_CTRL: begin
            s_axi_rdata <= {28'h000_0000, ctrl_reg};
          end
          SEL_ADDR: begin
            s_axi_rdata <= {{(32-ADDR_W){1'b0}}, addr_reg};
          end
          SEL_DATA: begin
            s_axi_rdata <= data_word(data_reg, mask_reg);
          end
          SEL_STAT: begin
            s_axi_rdata <= stat_word(busy, rd_reg);
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SRMC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ram sequencer; address only changes while strobe is high
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      ram_addr <= {ADDR_W{1'b0}};
      ram_wdata <= {DATA_W{1'b0}};
      per_bit_write_enable_n <= WEN_IDLE;
      write_strobe_n <= 1'b1;
      chip_enable_n <= 1'b1;
      latch_hold <= 1'b0;
      rd_reg <= {DATA_W{1'b0}};
      wait_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          latch_hold <= hold_req; // RULE_13
          if (go_reg) begin
            ram_addr <= addr_reg; // RULE_02 RULE_03
            ram_wdata <= data_reg;
            wait_reg <= 8'h00;
            if (ctrl_reg[`SRMC_CTRL_WR])
              state_reg <= hold_req ? ST_DIS : ST_EN;
            else begin
              chip_enable_n <= 1'b0;
              state_reg <= ST_READ;
            end
          end
        end
        ST_DIS: begin
          chip_enable_n <= 1'b1; // RULE_06 RULE_04
          state_reg <= ST_HOLD;
        end
        ST_HOLD: begin
          latch_hold <= 1'b1; // RULE_06 RULE_12 RULE_05
          state_reg <= ST_EN;
        end
        ST_EN: begin
          chip_enable_n <= 1'b0; // RULE_06
          // inverted mask onto active-low enables
          per_bit_write_enable_n <= mask_to_wen(mask_reg); // RULE_11 RULE_07
          // setup count before the strobe
          wait_reg <= wait_reg + WAIT_STEP;
          if (wait_reg + WAIT_STEP >= SETUP_CYC)
            state_reg <= ST_STB;
        end
        ST_STB: begin
          // one-cycle strobe low
          write_strobe_n <= 1'b0; // RULE_08 RULE_10
          state_reg <= ST_END;
        end
        ST_END: begin
          // strobe, enables and chip released together
          write_strobe_n <= 1'b1; // RULE_10
          per_bit_write_enable_n <= WEN_IDLE;
          chip_enable_n <= 1'b1;
          state_reg <= ST_IDLE;
        end
        ST_READ: begin
          // latch output sampled one cycle after access
          rd_reg <= ram_rdata; // RULE_01
          chip_enable_n <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // srmc_ctrl

// File: test/srmc_ram_model.sv
// behavioural 32x2 ram with strobe-edge write and output latch
// assumes the controller drives all pins; open collector pulls ignored
`timescale 1ns/1ps
module srmc_ram_model (
  // address, data and write controls
  input wire [4:0] ram_addr,
  input wire [1:0] ram_wdata,
  input wire [1:0] per_bit_write_enable_n,
  input wire write_strobe_n,
  input wire chip_enable_n,
  input wire latch_hold,
  // latched read data
  output reg [1:0] ram_rdata
);
  reg [1:0] mem [0:31];
  integer i;
  // write on the falling strobe only
  always @(negedge write_strobe_n) begin
    for (i = 0; i < 2; i = i + 1) begin
      if (!chip_enable_n && !per_bit_write_enable_n[i]) begin
        mem[ram_addr][i] <= ram_wdata[i];
      end
    end
  end
  // latch transparent only when enabled and not held
  always @(ram_addr or chip_enable_n or latch_hold or write_strobe_n) begin
    if (!latch_hold && !chip_enable_n) begin
      ram_rdata = mem[ram_addr];
    end
  end
endmodule // srmc_ram_model

// File: test/srmc_ctrl_sva.sv
// pin sequencing checks for the small ram controller
// assumes bind onto srmc_ctrl; single aclk domain
`timescale 1ns/1ps
module srmc_ctrl_sva #(
  parameter ADDR_W = 5,
  parameter DATA_W = 2
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // ram pins
  input wire [ADDR_W-1:0] ram_addr,
  input wire [DATA_W-1:0] ram_wdata,
  input wire [DATA_W-1:0] per_bit_write_enable_n,
  input wire write_strobe_n,
  input wire chip_enable_n,
  input wire latch_hold
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_hold_while_off: assert property ($rose(latch_hold) |-> chip_enable_n)
    else $error("latch hold raised while chip enabled");
  a_strobe_single: assert property ($fell(write_strobe_n) |=> write_strobe_n)
    else $error("strobe low longer than one cycle");
  a_setup_stable: assert property ($fell(write_strobe_n) |->
    $stable(per_bit_write_enable_n) && $stable(ram_addr) && $stable(ram_wdata))
    else $error("write controls moved at strobe");
  a_strobe_enabled: assert property (!write_strobe_n |-> !chip_enable_n)
    else $error("strobe while chip disabled");
  a_off_no_write: assert property (chip_enable_n |->
    per_bit_write_enable_n == {DATA_W{1'b1}}) else $error("enable while off");
  a_end_release: assert property ($rose(write_strobe_n) |-> chip_enable_n &&
    per_bit_write_enable_n == {DATA_W{1'b1}}) else $error("write not released");
  c_write: cover property ($fell(write_strobe_n));
  c_hold: cover property ($rose(latch_hold));
  c_read: cover property ($fell(chip_enable_n) && write_strobe_n);
endmodule // srmc_ctrl_sva
bind srmc_ctrl srmc_ctrl_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
  .per_bit_write_enable_n(per_bit_write_enable_n),
  .write_strobe_n(write_strobe_n), .chip_enable_n(chip_enable_n),
  .latch_hold(latch_hold));

// File: test/tb.sv
// self-checking bench: axi4-lite master plus ram model
// assumes srmc_ctrl register map from srmc_regs.vh
`timescale 1ns/1ps
`include "srmc_regs.vh"
module tb;
  reg aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  reg [3:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, s;
  wire awr, wr_, bv, arr, rv, wsn, cen, lh;
  wire [1:0] bresp, rresp, wd, ben, rd_;
  wire [31:0] rdata;
  wire [4:0] ra;
  integer num_errors = 0, comparisons = 0;
  always #20 aclk = ~aclk;
  srmc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .ram_addr(ra), .ram_wdata(wd),
    .per_bit_write_enable_n(ben), .write_strobe_n(wsn),
    .chip_enable_n(cen), .latch_hold(lh), .ram_rdata(rd_));
  srmc_ram_model ram (.ram_addr(ra), .ram_wdata(wd),
    .per_bit_write_enable_n(ben), .write_strobe_n(wsn),
    .chip_enable_n(cen), .latch_hold(lh), .ram_rdata(rd_));
  task chk(input [31:0] g, input [31:0] e); begin
    comparisons = comparisons + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  end endtask
  // handshakes judged on values settled before the sampling edge
  task wr(input [3:0] a, input [31:0] d);
    reg ta, tw, pa, pw;
    reg [1:0] r;
    begin
      awaddr <= a;
      wdata <= d;
      awv <= 1;
      wv <= 1;
      ta = 0;
      tw = 0;
      while (!(ta && tw)) begin
        @(negedge aclk);
        pa = awr & awv;
        pw = wr_ & wv;
        @(posedge aclk);
        if (pa) begin
          ta = 1;
          awv <= 0;
        end
        if (pw) begin
          tw = 1;
          wv <= 0;
        end
      end
      bready <= 1;
      pa = 0;
      while (!pa) begin
        @(negedge aclk);
        pa = bv;
        r = bresp;
        @(posedge aclk);
      end
      bready <= 0;
      // unaligned offsets are unmapped
      chk(r, (a[1:0] != 2'b00) ? `SRMC_RESP_SLVERR : `SRMC_RESP_OKAY);
    end
  endtask
  task rd(input [3:0] a);
    reg h;
    reg [1:0] r;
    begin
      araddr <= a;
      arv <= 1;
      h = 0;
      while (!h) begin
        @(negedge aclk);
        h = arr;
        @(posedge aclk);
      end
      arv <= 0;
      rready <= 1;
      h = 0;
      while (!h) begin
        @(negedge aclk);
        h = rv;
        r = rresp;
        s = rdata;
        @(posedge aclk);
      end
      rready <= 0;
      chk(r, (a[1:0] != 2'b00) ? `SRMC_RESP_SLVERR : `SRMC_RESP_OKAY);
    end
  endtask
  task op(input [4:0] a, input [5:0] dm, input [3:0] c);
    begin
      wr(`SRMC_ADDR_OFF, {27'h000_0000, a});
      wr(`SRMC_DATA_OFF, {26'h000_0000, dm});
      wr(`SRMC_CTRL_OFF, {28'h000_0000, c});
      s = 1;
      while (s[0] === 1'b1) rd(`SRMC_STAT_OFF);
    end
  endtask
  task t_reset;
    begin
      chk({cen, wsn, ben, lh}, 5'h1e);
      chk(ra, 5'h00);
    end
  endtask
  task t_mask;
    begin
      op(5'h13, 6'h32, 4'h3);
      op(5'h13, 6'h00, 4'h1);
      chk(s[5:4], 2'h2);
      op(5'h03, 6'h30, 4'h3);
      op(5'h03, 6'h13, 4'h3);
      op(5'h03, 6'h00, 4'h1);
      chk(s[5:4], 2'h1);
    end
  endtask
  task t_half;
    begin
      op(5'h13, 6'h00, 4'h1);
      chk(s[5:4], 2'h2);
    end
  endtask
  task t_hold;
    begin
      op(5'h13, 6'h31, 4'h7);
      chk({lh, rd_}, 3'h6);
      op(5'h13, 6'h00, 4'hd);
      chk({lh, s[5:4]}, 3'h1);
    end
  endtask
  task t_regs;
    begin
      rd(`SRMC_ADDR_OFF);
      chk(s, 32'h0000_0013);
      rd(`SRMC_DATA_OFF);
      chk(s, 32'h0000_0000);
      rd(`SRMC_CTRL_OFF);
      chk(s, 32'h0000_000c);
      wr(4'h2, 32'h0000_0001);
      rd(4'h6);
      chk(s, 32'h0000_0000);
    end
  endtask
  task summarize; begin
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  end endtask
  initial begin #200000; num_errors = num_errors + 1; summarize; end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset;
    t_mask;
    t_half;
    t_hold;
    t_regs;
    summarize;
  end
endmodule // tb
